// [design/motor_startup_config.sv]
// motor start-up configuration register with decoded settings
// assumes a same-clock register master; start/abort/done from the sequencer
//
// Functional notes
// - word at 0x40 resets to zero; bits 6 and 0 read zero
// - bits 31-30 choose align, double align, position detect, slow cycle
// - bits 29-26 pick current ramp rate; code f means unlimited
// - bits 25-22 pick align hold time, 10 ms up to 10 s
// - bits 21-17 pick align/slow cycle current cap, 7.5% to 100%
// - bits 16-14 pick position probe pulse rate, 50 Hz to 10 kHz
// - probe threshold equals bits 13-7 times base current over 128
// - bits 5-4 add 0, 30, 60 or 90 degrees lead
// - bits 3-2: one probe run, or average of 2, 3, 4
// - bit 1 picks open-loop cap: dedicated when 0, general when 1
// - dedicated open-loop cap is five bits at 31-27 of second word
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
module motor_startup_config #(
   parameter int CURR_W = 16
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   input wire logic seqStart,
   input wire logic seqDone,
   input wire logic seqAbort,
   input wire logic [CURR_W-1:0] baseCurrent,
   output logic seqActive,
   output logic [1:0] startupMethodSelect,
   output logic rampUnlimited,
   output logic [23:0] rampRateMilliAmpPerSec,
   output logic [31:0] alignHoldCycles,
   output logic [9:0] startupPhaseCurrentCap,
   output logic [31:0] positionProbePulseCycles,
   output logic [CURR_W-1:0] positionProbeCurrentThreshold,
   output logic [6:0] positionProbeLeadAngle,
   output logic [2:0] positionProbeRuns,
   output logic [9:0] openloopCurrentCap
);
   // narrower loses threshold resolution, wider overflows the product
   if (CURR_W < 8 || CURR_W > 24)
   begin : g_bad_width
      $error("CURR_W must lie between 8 and 24");
   end

   // cap tables are in tenths of a percent
   function automatic logic [9:0] capPermille(input logic [4:0] code);
      case (code)
         5'h00: capPermille = 10'h04b;
         5'h01: capPermille = 10'h050;
         5'h02: capPermille = 10'h055;
         5'h03: capPermille = 10'h05a;
         5'h04: capPermille = 10'h05f;
         5'h05: capPermille = 10'h064;
         5'h06: capPermille = 10'h06e;
         5'h07: capPermille = 10'h078;
         5'h08: capPermille = 10'h082;
         5'h09: capPermille = 10'h08c;
         5'h0a: capPermille = 10'h096;
         5'h0b: capPermille = 10'h0a0;
         5'h0c: capPermille = 10'h0aa;
         5'h0d: capPermille = 10'h0b4;
         5'h0e: capPermille = 10'h0c8;
         5'h0f: capPermille = 10'h0e1;
         5'h10: capPermille = 10'h0fa;
         5'h11: capPermille = 10'h113;
         5'h12: capPermille = 10'h12c;
         5'h13: capPermille = 10'h15e;
         5'h14: capPermille = 10'h190;
         5'h15: capPermille = 10'h1c2;
         5'h16: capPermille = 10'h1f4;
         5'h17: capPermille = 10'h226;
         5'h18: capPermille = 10'h258;
         5'h19: capPermille = 10'h2bc;
         5'h1a: capPermille = 10'h2ee;
         5'h1b: capPermille = 10'h320;
         5'h1c: capPermille = 10'h352;
         5'h1d: capPermille = 10'h384;
         5'h1e: capPermille = 10'h3b6;
         default: capPermille = 10'h3e8;
      endcase
   endfunction : capPermille

   // ramp in mA/s so the 0.1 A/s step stays exact
   function automatic logic [23:0] rampMa(input logic [3:0] code);
      case (code)
         4'h0: rampMa = 24'h000064;
         4'h1: rampMa = 24'h0003e8;
         4'h2: rampMa = 24'h001388;
         4'h3: rampMa = 24'h002710;
         4'h4: rampMa = 24'h003a98;
         4'h5: rampMa = 24'h0061a8;
         4'h6: rampMa = 24'h00c350;
         4'h7: rampMa = 24'h0186a0;
         4'h8: rampMa = 24'h0249f0;
         4'h9: rampMa = 24'h030d40;
         4'ha: rampMa = 24'h03d090;
         4'hb: rampMa = 24'h07a120;
         4'hc: rampMa = 24'h0f4240;
         4'hd: rampMa = 24'h1e8480;
         4'he: rampMa = 24'h4c4b40;
         default: rampMa = 24'h000000;
      endcase
   endfunction : rampMa

   // align hold in ms; turned into cycles at the output register
   function automatic logic [31:0] alignMs(input logic [3:0] code);
      case (code)
         4'h0: alignMs = 32'd10;
         4'h1: alignMs = 32'd50;
         4'h2: alignMs = 32'd100;
         4'h3: alignMs = 32'd200;
         4'h4: alignMs = 32'd300;
         4'h5: alignMs = 32'd400;
         4'h6: alignMs = 32'd500;
         4'h7: alignMs = 32'd750;
         4'h8: alignMs = 32'd1000;
         4'h9: alignMs = 32'd1500;
         4'ha: alignMs = 32'd2000;
         4'hb: alignMs = 32'd3000;
         4'hc: alignMs = 32'd4000;
         4'hd: alignMs = 32'd5000;
         4'he: alignMs = 32'd7500;
         default: alignMs = 32'd10000;
      endcase
   endfunction : alignMs

   // probe rate in Hz; the period in cycles is taken at the output
   function automatic logic [31:0] probeHz(input logic [2:0] code);
      case (code)
         3'h0: probeHz = 32'd50;
         3'h1: probeHz = 32'd100;
         3'h2: probeHz = 32'd250;
         3'h3: probeHz = 32'd500;
         3'h4: probeHz = 32'd1000;
         3'h5: probeHz = 32'd2000;
         3'h6: probeHz = 32'd5000;
         default: probeHz = 32'd10000;
      endcase
   endfunction : probeHz

   // live register words and their next values
   logic [31:0] cfgWord;
   logic [31:0] next_cfgWord;
   logic [31:0] cfg2Word;
   logic [31:0] next_cfg2Word;
   logic [31:0] genCapWord;
   logic [31:0] next_genCapWord;

   logic [31:0] next_regRdData;

   // snapshot of the live words, refreshed only while idle
   logic [31:0] frozen1;
   logic [31:0] next_frozen1;
   logic [4:0] frozenOl;
   logic [4:0] next_frozenOl;
   logic [4:0] frozenGen;
   logic [4:0] next_frozenGen;

   msc_pkg::msc_state_t state;
   msc_pkg::msc_state_t next_state;

   // register file and read port
   // masked bits never store, so reserved bits always read back zero
   // the reply is registered and dropped to zero after one cycle
   always_comb
   begin
      next_cfgWord = cfgWord;
      next_cfg2Word = cfg2Word;
      next_genCapWord = genCapWord;
      next_regRdData = 32'h0000_0000;
      if (regWrite)
      begin
         case (regAddr)
            msc_pkg::REG_STARTUP1:
               next_cfgWord = regWrData & msc_pkg::STARTUP1_WMASK;
            msc_pkg::REG_STARTUP2:
               next_cfg2Word = regWrData & msc_pkg::STARTUP2_WMASK;
            msc_pkg::REG_GENCAP:
               next_genCapWord = regWrData & msc_pkg::GENCAP_WMASK;
            default:
               next_cfgWord = cfgWord;
         endcase
      end
      if (regRead)
      begin
         case (regAddr)
            msc_pkg::REG_STARTUP1: next_regRdData = cfgWord;
            msc_pkg::REG_STARTUP2: next_regRdData = cfg2Word;
            msc_pkg::REG_GENCAP: next_regRdData = genCapWord;
            msc_pkg::REG_STATUS:
               next_regRdData = {29'h0000_0000, state};
            default: next_regRdData = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         cfgWord <= msc_pkg::STARTUP1_RESET;
         cfg2Word <= msc_pkg::STARTUP2_RESET;
         genCapWord <= msc_pkg::GENCAP_RESET;
         regRdData <= 32'h0000_0000;
      end
      else
      begin
         cfgWord <= next_cfgWord;
         cfg2Word <= next_cfg2Word;
         genCapWord <= next_genCapWord;
         regRdData <= next_regRdData;
      end
   end

   // snapshot: software may rewrite mid-start without disturbing the motor
   always_comb
   begin
      next_state = state;
      next_frozen1 = frozen1;
      next_frozenOl = frozenOl;
      next_frozenGen = frozenGen;
      case (state)
         msc_pkg::MSC_IDLE:
         begin
            // idle tracks live values so outputs are meaningful pre-start
            next_frozen1 = cfgWord;
            next_frozenOl = cfg2Word[msc_pkg::OLCAP_HI -: 5];
            next_frozenGen = genCapWord[4:0];
            if (seqStart)
               next_state = msc_pkg::MSC_RUN;
         end
         // run and end hold the snapshot; a fresh start is ignored here
         msc_pkg::MSC_RUN:
            if (seqDone || seqAbort)
               next_state = msc_pkg::MSC_END;
         // one cycle in end before idle resumes tracking
         msc_pkg::MSC_END:
            next_state = msc_pkg::MSC_IDLE;
         default:
            next_state = msc_pkg::MSC_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state <= msc_pkg::MSC_IDLE;
         // snapshot starts at the reset word, so outputs decode code zero
         frozen1 <= msc_pkg::STARTUP1_RESET;
         frozenOl <= 5'h00;
         frozenGen <= 5'h00;
      end
      else
      begin
         state <= next_state;
         frozen1 <= next_frozen1;
         frozenOl <= next_frozenOl;
         frozenGen <= next_frozenGen;
      end
   end

   // decoded settings, registered from the snapshot
   // each field is cut out once so the lookups below read plainly
   logic [1:0] methodCode;
   logic [3:0] rampCode;
   logic [3:0] alignCode;
   logic [4:0] phaseCapCode;
   logic [2:0] rateCode;
   logic [6:0] thrCode;
   logic [1:0] leadCode;
   logic [1:0] repeatCode;
   logic capFromGeneral;
   logic [CURR_W+6:0] thrProduct;
   logic [31:0] alignMsVal;
   logic [31:0] probeHzVal;

   always_comb
   begin
      methodCode = frozen1[msc_pkg::METHOD_HI -: 2];
      rampCode = frozen1[msc_pkg::RAMP_HI -: 4];
      alignCode = frozen1[msc_pkg::ALIGNT_HI -: 4];
      phaseCapCode = frozen1[msc_pkg::PHCAP_HI -: 5];
      rateCode = frozen1[msc_pkg::PRATE_HI -: 3];
      thrCode = frozen1[msc_pkg::PTHR_HI -: 7];
      leadCode = frozen1[msc_pkg::LEAD_HI -: 2];
      repeatCode = frozen1[msc_pkg::REPEAT_HI -: 2];
      capFromGeneral = frozen1[msc_pkg::CAPSRC_BIT];
      // full-width product; the divide by 128 is the part-select below
      thrProduct = baseCurrent * thrCode;
      alignMsVal = alignMs(alignCode);
      probeHzVal = probeHz(rateCode);
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         seqActive <= 1'b0;
         startupMethodSelect <= 2'h0;
         rampUnlimited <= 1'b0;
         rampRateMilliAmpPerSec <= 24'h000000;
         alignHoldCycles <= 32'h0000_0000;
         startupPhaseCurrentCap <= 10'h000;
         positionProbePulseCycles <= 32'h0000_0000;
         positionProbeCurrentThreshold <= '0;
         positionProbeLeadAngle <= 7'h00;
         positionProbeRuns <= 3'h0;
         openloopCurrentCap <= 10'h000;
      end
      else
      begin
         // one cycle behind state: rises on the second edge after start
         seqActive <= (state == msc_pkg::MSC_RUN);
         startupMethodSelect <= methodCode;
         rampUnlimited <= (rampCode == 4'hf);
         rampRateMilliAmpPerSec <= rampMa(rampCode);
         // ms to cycles: 125000 cycles per ms, fits 32 bits up to 10 s
         alignHoldCycles <=
            32'(alignMsVal * 32'(msc_pkg::CLK_HZ / 1000));
         startupPhaseCurrentCap <= capPermille(phaseCapCode);
         // every rate divides the clock evenly, so the period is exact
         positionProbePulseCycles <=
            32'(msc_pkg::CLK_HZ) / probeHzVal;
         positionProbeCurrentThreshold <= thrProduct[CURR_W+6:7];
         positionProbeLeadAngle <= 7'(30 * leadCode);
         positionProbeRuns <= 3'(repeatCode) + 3'h1;
         // source bit picks which stored cap code feeds the open-loop cap
         if (capFromGeneral)
            openloopCurrentCap <= capPermille(frozenGen);
         else
            openloopCurrentCap <= capPermille(frozenOl);
      end
   end
endmodule : motor_startup_config

// [design/msc_pkg.sv]
// motor start-up configuration: offsets, field layout, reset values, write masks, encodings
// assumes a 125 MHz controller clock and one 32-bit word per register
package msc_pkg;
   localparam logic [7:0] REG_STARTUP1 = 8'h40;
   localparam logic [7:0] REG_STARTUP2 = 8'h44;
   localparam logic [7:0] REG_GENCAP = 8'h48;
   localparam logic [7:0] REG_STATUS = 8'h4c;
   localparam logic [31:0] STARTUP1_RESET = 32'h0000_0000;
   localparam logic [31:0] STARTUP2_RESET = 32'h0000_0000;
   localparam logic [31:0] GENCAP_RESET = 32'h0000_0000;
   localparam logic [31:0] STARTUP1_WMASK = 32'hffff_ffbe;
   localparam logic [31:0] STARTUP2_WMASK = 32'hf800_0000;
   localparam logic [31:0] GENCAP_WMASK = 32'h0000_001f;
   localparam int METHOD_HI = 31;
   localparam int RAMP_HI = 29;
   localparam int ALIGNT_HI = 25;
   localparam int PHCAP_HI = 21;
   localparam int PRATE_HI = 16;
   localparam int PTHR_HI = 13;
   localparam int LEAD_HI = 5;
   localparam int REPEAT_HI = 3;
   localparam int CAPSRC_BIT = 1;
   localparam int OLCAP_HI = 31;
   localparam int CLK_HZ = 125_000_000;
   typedef enum logic [1:0] {
      MSC_ALIGN = 2'h0,
      MSC_DOUBLE_ALIGN = 2'h1,
      MSC_POSITION_DETECT = 2'h2,
      MSC_SLOW_FIRST_CYCLE = 2'h3
   } msc_method_t;
   typedef enum logic [2:0] {
      MSC_IDLE = 3'h1,
      MSC_RUN = 3'h2,
      MSC_END = 3'h4
   } msc_state_t;
endpackage : msc_pkg

// [testbench/msc_seq_model.sv]
// sequencer stand-in: start pulse, then done or abort after runLen edges
// assumes kick is a one-cycle request from the bench on the same clock
`timescale 1ns/1ns
module msc_seq_model (
   input wire logic clk_sys,
   input wire logic kick,
   input wire logic quit,
   input wire logic [7:0] runLen,
   output logic seqStart = 1'b0,
   output logic seqDone = 1'b0,
   output logic seqAbort = 1'b0
);
   int cnt = 0;
   always @(posedge clk_sys)
   begin
      seqStart <= kick && cnt == 0;
      seqDone <= !quit && cnt == 1;
      seqAbort <= quit && cnt == 1;
      if (kick && cnt == 0)
         cnt <= int'(runLen);
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
endmodule : msc_seq_model

// [testbench/msc_assertions.sv]
// checker for read port replies and start-up run hand-over
// assumes one clock with synchronous active-high reset
`timescale 1ns/1ns
module msc_assertions (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic regRead,
   input wire logic [31:0] regRdData,
   input wire logic seqStart,
   input wire logic seqDone,
   input wire logic seqAbort,
   input wire logic seqActive,
   input wire logic [1:0] startupMethodSelect,
   input wire logic rampUnlimited,
   input wire logic [23:0] rampRateMilliAmpPerSec
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   sequence s_start;
      seqStart && !seqActive && !$past(seqActive) && !$past(seqStart);
   endsequence
   sequence s_stop;
      seqActive && (seqDone || seqAbort);
   endsequence
   rdata_idle_a: assert property (!$past(regRead)
      |-> regRdData == 32'h0) else $error("read data not zero outside reply");
   rsvd_zero_a: assert property ($past(regRead)
      && $past(regAddr) == 8'h40
      |-> !regRdData[6] && !regRdData[0]) else $error("reserved bit set");
   unmapped_rd_a: assert property ($past(regRead)
      && $past(regAddr) == 8'h50
      |-> regRdData == 32'h0) else $error("unmapped read not zero");
   ramp_unlim_a: assert property (rampUnlimited
      |-> !rampRateMilliAmpPerSec) else $error("ramp rate set while unlimited");
   start_active_a: assert property (s_start
      |-> ##1 !seqActive ##1 seqActive) else $error("run flag late after start");
   stop_release_a: assert property (s_stop
      |-> ##1 seqActive ##1 !seqActive) else $error("run flag wrong after stop");
   frozen_method_a: assert property (seqActive
      && $past(seqActive)
      |-> $stable(startupMethodSelect)) else $error("method moved in run");
   frozen_ramp_a: assert property (seqActive
      && $past(seqActive)
      |-> $stable(rampRateMilliAmpPerSec)) else $error("ramp moved in run");
endmodule : msc_assertions
bind motor_startup_config msc_assertions i_chk (.clk_sys, .rst, .regAddr,
   .regRead, .regRdData, .seqStart, .seqDone, .seqAbort, .seqActive,
   .startupMethodSelect, .rampUnlimited, .rampRateMilliAmpPerSec);

// [testbench/tb.sv]
// bench: register port, decode of each field, settings frozen in a run
// assumes the sequencer stand-in and the bound checker
`timescale 1ns/1ns
module tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [15:0] baseCurrent = 16'h0;
   logic kick = 1'b0;
   logic quit = 1'b0;
   logic [7:0] runLen = 8'h0c;
   logic [31:0] regRdData, alignHoldCycles, positionProbePulseCycles;
   logic seqStart, seqDone, seqAbort, seqActive, rampUnlimited;
   logic [1:0] startupMethodSelect;
   logic [23:0] rampRateMilliAmpPerSec;
   logic [9:0] startupPhaseCurrentCap, openloopCurrentCap;
   logic [15:0] positionProbeCurrentThreshold;
   logic [6:0] positionProbeLeadAngle;
   logic [2:0] positionProbeRuns;
   logic [4:0] olCap = 5'h0;
   logic [4:0] genCap = 5'h0;
   logic rdLag = 1'b0;
   logic [31:0] expQ[$];
   int n_fail = 0;
   int cmp_count = 0;
   int capT[32] = '{75, 80, 85, 90, 95, 100, 110, 120, 130, 140, 150, 160,
      170, 180, 200, 225, 250, 275, 300, 350, 400, 450, 500, 550, 600, 700,
      750, 800, 850, 900, 950, 1000};
   int alnT[16] = '{10, 50, 100, 200, 300, 400, 500, 750, 1000, 1500, 2000,
      3000, 4000, 5000, 7500, 10000};
   int hzT[8] = '{50, 100, 250, 500, 1000, 2000, 5000, 10000};
   // mA/s; code f has no limit, shown as zero
   int rmpT[16] = '{100, 1000, 5000, 10000, 15000, 25000, 50000, 100000,
      150000, 200000, 250000, 500000, 1000000, 2000000, 5000000, 0};
   msc_seq_model i_seq (.*);
   motor_startup_config i_dut (.*);
   initial
   begin
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // strobes stay up into a following call, so no signal is set twice
   // in one time step; dec drops them before it waits
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      regRead <= 1'b0;
      @(posedge clk_sys);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expQ.push_back(e);
      regAddr <= a;
      regRead <= 1'b1;
      regWrite <= 1'b0;
      @(posedge clk_sys);
   endtask : rd
   // reply stands only in the cycle after the strobe
   always @(negedge clk_sys)
   begin
      if (rdLag)
         chk("readback", regRdData, expQ.pop_front());
      rdLag = regRead;
   end
   // extra edge of margin: outputs lag a write or run end by two
   task automatic dec(input logic [31:0] w);
      regWrite <= 1'b0;
      regRead <= 1'b0;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("method", startupMethodSelect, w[31:30]);
      chk("ramp", rampRateMilliAmpPerSec, rmpT[w[29:26]]);
      chk("unlim", rampUnlimited, w[29:26] == 4'hf);
      chk("align", alignHoldCycles, alnT[w[25:22]] * 125000);
      chk("phcap", startupPhaseCurrentCap, capT[w[21:17]]);
      chk("pulse", positionProbePulseCycles,
         125000000 / hzT[w[16:14]]);
      chk("thr", positionProbeCurrentThreshold,
         (32'(baseCurrent) * w[13:7]) >> 7);
      chk("lead", positionProbeLeadAngle, w[5:4] * 30);
      chk("runs", positionProbeRuns, w[3:2] + 1);
      chk("olcap", openloopCurrentCap,
         capT[w[1] ? genCap : olCap]);
      @(posedge clk_sys);
   endtask : dec
   initial
   begin
      logic [31:0] w;
      logic [31:0] v;
      void'($urandom(15));
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      rd(8'h40, 32'h0);
      rd(8'h50, 32'h0);
      rd(8'h4c, 32'h1);
      w = 32'h0;
      dec(w);
      for (int i = 0; i < 32; i++)
      begin
         olCap = 5'($urandom);
         genCap = 5'($urandom);
         baseCurrent <= 16'($urandom);
         wr(8'h44, {olCap, 27'h0});
         wr(8'h48, {27'h0, genCap});
         w = {i[1:0], i[3:0], 4'(i + 5), i[4:0], i[2:0], 7'($urandom),
            1'b0, i[3:2], 2'(i + 1), i[2], 1'b0};
         wr(8'h40, w | 32'h41);
         rd(8'h40, w);
         rd(8'h44, {olCap, 27'h0});
         rd(8'h48, {27'h0, genCap});
         dec(w);
      end
      for (int k = 0; k < 2; k++)
      begin
         v = w;
         quit <= k[0];
         kick <= 1'b1;
         @(posedge clk_sys);
         kick <= 1'b0;
         @(posedge clk_sys);
         w = $urandom & 32'hffffffbe;
         wr(8'h40, w);
         dec(v);
         chk("active", seqActive, 1'b1);
         for (int n = 0; seqActive !== 1'b0; n++)
         begin
            if (n == 60)
            begin
               n_fail++;
               tally_and_finish;
            end
            @(posedge clk_sys);
         end
         dec(w);
      end
      tally_and_finish;
   end
endmodule : tb
